/* File: rtl/pmtx_pkg.sv */
// Contract
// R1: two-bit power state, 00 full to 11 D3hot
// R2: unsupported power state write completes, value dropped
// R3: burst threshold successes raise transmit-complete event
// R4: idle enable counts timeout down per speed step
// R5: timeout expiry before transmit start raises idle
// R6: boot select steers shared pin in four-LED mode
// R7: device clears read request when byte arrives
// R8: device clears write request when write completes
// R9: 17-bit address and 8-bit data, reset zero
// R10: software loads fields first, polls request clear
package pmtx_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_TX_BURST = 8'h9c;
    localparam logic [7:0] ADDR_FROM = 8'ha0;
    localparam logic [7:0] ADDR_PM_CSR = 8'he0;
    localparam logic [7:0] ADDR_IRQ_EN = 8'he4;
    localparam logic [7:0] ADDR_LED_CFG = 8'he8;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PS_LSB = 0;
    localparam int TBT_LSB = 16;
    localparam int TIMEOUT_LSB = 0;
    localparam int BOOT_SEL_BIT = 31;
    localparam int RD_REQ_BIT = 27;
    localparam int WR_REQ_BIT = 26;
    localparam int ROM_ADDR_LSB = 8;
    localparam int ROM_DATA_LSB = 0;
    localparam int IDLE_EN_BIT = 28;
    localparam int FOUR_LED_BIT = 23;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [1:0] PS_RST = 2'h0;
    localparam logic [4:0] TBT_RST = 5'h05;
    localparam logic [11:0] TIMEOUT_RST = 12'h000;
    localparam logic BOOT_SEL_RST = 1'b1;
    localparam logic [16:0] ROM_ADDR_RST = 17'h00000;
    localparam logic [7:0] ROM_DATA_RST = 8'h00;
    // power states accepted on write, one bit per encoding
    localparam logic [3:0] PS_SUPPORT = 4'h9;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int TICK_100_NS = 2560;
    localparam int TICK_10_NS = 25600;
    localparam int TICK_100_CYC = (TICK_100_NS * CLK_MHZ + 999) / 1000;
    localparam int TICK_10_CYC = (TICK_10_NS * CLK_MHZ + 999) / 1000;
    localparam int ROM_ACCESS_NS = 120;
    localparam int ROM_SYNC_CYC = 3;
    localparam int ROM_ACCESS_CYC = (ROM_ACCESS_NS * CLK_MHZ + 999) / 1000 + ROM_SYNC_CYC;

    typedef enum logic [2:0]
    {
        rom_idle = 3'b001,
        rom_read = 3'b010,
        rom_write = 3'b100
    } pmtx_rom_state_t;

endpackage

/* File: rtl/pmtx_idle_timer.sv */
`timescale 1ns/100ps
module pmtx_idle_timer #(
    parameter int TICK_10_CYC = pmtx_pkg::TICK_10_CYC
) (
    input wire logic hclk, // bus clock
    input wire logic hresetn, // async reset, low
    input wire logic enable, // idle detection enabled
    input wire logic speed_100, // 1 = 100 Mb/s step
    input wire logic load, // restart from timeout
    input wire logic [11:0] timeout, // step count
    output logic expire // one-cycle idle event
);

    localparam logic [12:0] PER_100 = 13'(pmtx_pkg::TICK_100_CYC - 1);
    localparam logic [12:0] PER_10 = 13'(TICK_10_CYC - 1);

    logic [12:0] pre;
    logic [11:0] remaining;
    logic armed;

    wire [12:0] period = speed_100 ? PER_100 : PER_10;
    wire tick = (pre == 13'h0000);
    wire last_step = armed && tick && (remaining == 12'h001);

    // ------------------------------------------------------------
    // prescaled countdown
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pre <= 13'h0000;
            remaining <= 12'h000;
            armed <= 1'b0;
            expire <= 1'b0;
        end
        else
        begin
            expire <= 1'b0;
            if (!enable)
            begin
                armed <= 1'b0;
                pre <= 13'h0000;
            end
            else if (load)
            begin
                remaining <= timeout; // see R4
                armed <= (timeout != 12'h000);
                pre <= period;
            end
            else if (armed && tick)
            begin
                remaining <= remaining - 12'h001; // see R4
                pre <= period;
                armed <= !last_step;
                expire <= last_step; // see R5
            end
            else if (armed)
            begin
                pre <= pre - 13'h0001;
            end
        end
    end

    chk_idle_expiry_cause: assert property (@(posedge hclk) disable iff (!hresetn) // see R5
        expire |-> $past(armed) && $past(remaining) == 12'h001 && $past(enable))
        else $error("idle event without a finished countdown");

    chk_idle_gated_off: assert property (@(posedge hclk) disable iff (!hresetn) // see R4
        !enable |=> !expire ##1 !expire)
        else $error("idle event while detection disabled");

endmodule

/* File: rtl/pmtx_csr_bank.sv */
`timescale 1ns/100ps
module pmtx_csr_bank #(
    parameter int TICK_10_CYC = pmtx_pkg::TICK_10_CYC
) (
    input wire logic hclk, // bus clock, 250 MHz
    input wire logic hresetn, // async reset, low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // 1 = write
    input wire logic [2:0] hsize, // word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    input wire logic tx_burst_done, // successful burst write
    input wire logic tx_burst_fail, // failed burst write
    input wire logic tx_start, // packet transmit begins
    input wire logic speed_100, // 1 = 100 Mb/s
    input wire logic duplex_collision_led, // led drive
    output logic [1:0] power_state, // current state
    output logic tx_complete_event, // one-cycle pulse
    output logic tx_idle_event, // one-cycle pulse
    output logic shared_pin_out, // led or address 16
    output logic [16:0] rom_addr, // rom byte address
    input wire logic [7:0] rom_data_in, // rom data pins in
    output logic [7:0] rom_data_out, // rom data pins out
    output logic rom_data_oe, // drive data pins
    output logic rom_cs_n, // chip select, low
    output logic rom_oe_n, // output enable, low
    output logic rom_we_n // write enable, low
);

    localparam logic [5:0] ROM_CYC = 6'(pmtx_pkg::ROM_ACCESS_CYC - 1);
    localparam int ROM_MAX = 48;

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic wr_pend;
    logic rd_pend;
    logic [7:0] xfer_addr;
    logic [4:0] tx_burst_threshold;
    logic [11:0] tx_timeout_value;
    logic boot_addr16_select;
    logic rd_req;
    logic wr_req;
    logic [7:0] rom_data;
    logic tx_idle_irq_enable;
    logic idle_en_q;
    logic four_led_select;
    logic [4:0] burst_cnt;
    logic [7:0] rom_s1;
    logic [7:0] rom_s2;
    logic [7:0] rom_s3;
    logic [5:0] rom_cnt;
    pmtx_pkg::pmtx_rom_state_t state;
    pmtx_pkg::pmtx_rom_state_t next_state;

    wire take = hsel && hready && htrans[1];
    wire sel_pm = (xfer_addr == pmtx_pkg::ADDR_PM_CSR);
    wire sel_burst_reg = (xfer_addr == pmtx_pkg::ADDR_TX_BURST);
    wire sel_from = (xfer_addr == pmtx_pkg::ADDR_FROM);
    wire sel_irq = (xfer_addr == pmtx_pkg::ADDR_IRQ_EN);
    wire sel_led = (xfer_addr == pmtx_pkg::ADDR_LED_CFG);
    wire wr_pm = wr_pend && sel_pm;
    wire wr_burst_reg = wr_pend && sel_burst_reg;
    wire wr_from = wr_pend && sel_from;
    wire [1:0] ps_new = hwdata[pmtx_pkg::PS_LSB +: 2];
    wire ps_ok = pmtx_pkg::PS_SUPPORT[ps_new];

    wire [31:0] rd_pm = {30'h00000000, power_state};
    wire [31:0] rd_burst_reg = {11'h000, tx_burst_threshold, 4'h0, tx_timeout_value};
    wire [31:0] rd_from = {boot_addr16_select, 3'h0, rd_req, wr_req, 1'b0, rom_addr, rom_data};
    wire [31:0] rd_irq = {3'h0, tx_idle_irq_enable, 28'h0000000};
    wire [31:0] rd_led = {8'h00, four_led_select, 23'h000000};
    wire [31:0] rd_mux = sel_pm ? rd_pm :
                         sel_burst_reg ? rd_burst_reg :
                         sel_from ? rd_from :
                         sel_irq ? rd_irq :
                         sel_led ? rd_led : 32'h00000000;

    // reads take one wait state so a write just before is seen
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            xfer_addr <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
        end
        else
        begin
            wr_pend <= take && hwrite;
            rd_pend <= take && !hwrite;
            hreadyout <= !(take && !hwrite);
            if (take)
            begin
                xfer_addr <= {haddr[7:2], 2'b00};
            end
            if (rd_pend)
            begin
                hrdata <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // rom access sequencer
    // ------------------------------------------------------------
    wire rom_end = (rom_cnt == 6'h00);
    wire rom_stable = (rom_s2 == rom_s3);
    wire rd_finish = (state == pmtx_pkg::rom_read) && (next_state == pmtx_pkg::rom_idle);
    wire wr_finish = (state == pmtx_pkg::rom_write) && (next_state == pmtx_pkg::rom_idle);

    always_comb
    begin
        next_state = state;
        case (state)
            pmtx_pkg::rom_idle:
            begin
                if (rd_req)
                    next_state = pmtx_pkg::rom_read;
                else if (wr_req)
                    next_state = pmtx_pkg::rom_write;
            end
            pmtx_pkg::rom_read:
            begin
                // hold until synchronised data settles
                if (rom_end && rom_stable)
                    next_state = pmtx_pkg::rom_idle;
            end
            pmtx_pkg::rom_write:
            begin
                if (rom_end)
                    next_state = pmtx_pkg::rom_idle;
            end
            default:
            begin
                next_state = pmtx_pkg::rom_idle;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= pmtx_pkg::rom_idle;
            rom_cnt <= ROM_CYC;
            rom_s1 <= 8'h00;
            rom_s2 <= 8'h00;
            rom_s3 <= 8'h00;
            rom_cs_n <= 1'b1;
            rom_oe_n <= 1'b1;
            rom_we_n <= 1'b1;
            rom_data_oe <= 1'b0;
        end
        else
        begin
            state <= next_state;
            rom_s1 <= rom_data_in;
            rom_s2 <= rom_s1;
            rom_s3 <= rom_s2;
            rom_cnt <= (state == pmtx_pkg::rom_idle) ? ROM_CYC :
                       rom_end ? rom_cnt : rom_cnt - 6'h01;
            rom_cs_n <= (next_state == pmtx_pkg::rom_idle);
            rom_oe_n <= (next_state != pmtx_pkg::rom_read);
            rom_we_n <= (next_state != pmtx_pkg::rom_write);
            rom_data_oe <= (next_state == pmtx_pkg::rom_write);
        end
    end

    // ------------------------------------------------------------
    // registers; a software write is applied last so a set wins
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            power_state <= pmtx_pkg::PS_RST;
            tx_burst_threshold <= pmtx_pkg::TBT_RST;
            tx_timeout_value <= pmtx_pkg::TIMEOUT_RST;
            boot_addr16_select <= pmtx_pkg::BOOT_SEL_RST;
            rd_req <= 1'b0;
            wr_req <= 1'b0;
            rom_addr <= pmtx_pkg::ROM_ADDR_RST;
            rom_data <= pmtx_pkg::ROM_DATA_RST;
            tx_idle_irq_enable <= 1'b0;
            four_led_select <= 1'b0;
        end
        else
        begin
            if (rd_finish)
            begin
                rd_req <= 1'b0; // see R7
                rom_data <= rom_s3; // see R9
            end
            if (wr_finish)
            begin
                wr_req <= 1'b0; // see R8
            end
            if (wr_pm && ps_ok)
            begin
                power_state <= ps_new; // see R1, see R2
            end
            if (wr_burst_reg)
            begin
                tx_burst_threshold <= hwdata[pmtx_pkg::TBT_LSB +: 5];
                tx_timeout_value <= hwdata[pmtx_pkg::TIMEOUT_LSB +: 12];
            end
            if (wr_from)
            begin
                boot_addr16_select <= hwdata[pmtx_pkg::BOOT_SEL_BIT];
                rd_req <= hwdata[pmtx_pkg::RD_REQ_BIT];
                wr_req <= hwdata[pmtx_pkg::WR_REQ_BIT];
                rom_addr <= hwdata[pmtx_pkg::ROM_ADDR_LSB +: 17]; // see R9
                rom_data <= hwdata[pmtx_pkg::ROM_DATA_LSB +: 8];
            end
            if (wr_pend && sel_irq)
            begin
                tx_idle_irq_enable <= hwdata[pmtx_pkg::IDLE_EN_BIT];
            end
            if (wr_pend && sel_led)
            begin
                four_led_select <= hwdata[pmtx_pkg::FOUR_LED_BIT];
            end
        end
    end

    assign rom_data_out = rom_data;

    // ------------------------------------------------------------
    // transmit burst counting, idle timer, shared pin
    // ------------------------------------------------------------
    wire [4:0] burst_inc = burst_cnt + 5'h01;
    wire burst_hit = tx_burst_done && !tx_burst_fail && (burst_inc >= tx_burst_threshold);
    wire idle_load = tx_start || wr_burst_reg || (tx_idle_irq_enable && !idle_en_q);
    // the register lands on the same edge, so a write reloads from the bus word
    wire [11:0] load_timeout = wr_burst_reg ? hwdata[pmtx_pkg::TIMEOUT_LSB +: 12] :
                               tx_timeout_value;
    wire pin_sel = four_led_select && boot_addr16_select;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            burst_cnt <= 5'h00;
            tx_complete_event <= 1'b0;
            idle_en_q <= 1'b0;
            shared_pin_out <= 1'b0;
        end
        else
        begin
            idle_en_q <= tx_idle_irq_enable;
            tx_complete_event <= burst_hit; // see R3
            if (tx_burst_fail || burst_hit)
                burst_cnt <= 5'h00;
            else if (tx_burst_done)
                burst_cnt <= burst_inc;
            shared_pin_out <= pin_sel ? rom_addr[16] : duplex_collision_led; // see R6
        end
    end

    pmtx_idle_timer #(
        .TICK_10_CYC(TICK_10_CYC)
    ) u_idle_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(tx_idle_irq_enable),
        .speed_100(speed_100),
        .load(idle_load),
        .timeout(load_timeout),
        .expire(tx_idle_event)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence seq_rd_done;
        rd_finish && !wr_from;
    endsequence

    sequence seq_wr_done;
        wr_finish && !wr_from;
    endsequence

    chk_ps_accepted: assert property (@(posedge hclk) disable iff (!hresetn) // see R1
        wr_pm && ps_ok |=> power_state == $past(ps_new))
        else $error("supported power state not taken");

    chk_ps_dropped: assert property (@(posedge hclk) disable iff (!hresetn) // see R2
        wr_pm && !ps_ok |=> $stable(power_state) && hreadyout)
        else $error("unsupported power state changed state");

    chk_burst_event: assert property (@(posedge hclk) disable iff (!hresetn) // see R3
        tx_burst_done && !tx_burst_fail && burst_inc >= tx_burst_threshold
        |=> tx_complete_event && burst_cnt == 5'h00)
        else $error("burst threshold reached without event");

    chk_pin_select: assert property (@(posedge hclk) disable iff (!hresetn) // see R6
        ##1 shared_pin_out == ($past(pin_sel) ? $past(rom_addr[16]) : $past(duplex_collision_led)))
        else $error("shared pin shows wrong function");

    chk_read_clear: assert property (@(posedge hclk) disable iff (!hresetn) // see R7
        seq_rd_done |=> !rd_req && rom_data == $past(rom_s3) && !rom_cs_n == 1'b0)
        else $error("read request not cleared with data");

    chk_write_clear: assert property (@(posedge hclk) disable iff (!hresetn) // see R8
        seq_wr_done |=> !wr_req && rom_we_n && !rom_data_oe)
        else $error("write request not cleared on completion");

    chk_rom_bounded: assert property (@(posedge hclk) disable iff (!hresetn) // see R9
        state == pmtx_pkg::rom_idle && (rd_req || wr_req) && !wr_from
        |=> !rom_cs_n ##[1:ROM_MAX] rom_cs_n)
        else $error("rom access did not finish in time");

    chk_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
        take && !hwrite |=> !hreadyout ##1 hreadyout && !hresp)
        else $error("read wait state wrong");

endmodule

/* File: tb/pmtx_csr_bank_tb_top.sv */
`timescale 1ns/100ps
module pmtx_csr_bank_tb_top;
    // short 10M step keeps the idle timer runs brief
    localparam int TICK10 = 16;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic tx_burst_done = 1'b0;
    logic tx_burst_fail = 1'b0;
    logic tx_start = 1'b0;
    logic speed_100 = 1'b0;
    logic led = 1'b0;
    logic [1:0] power_state;
    logic tx_complete_event;
    logic tx_idle_event;
    logic shared_pin_out;
    logic [16:0] rom_addr;
    logic [7:0] rom_data_in = 8'h00;
    logic [7:0] rom_byte = 8'h5a;
    logic [7:0] rom_data_out;
    logic rom_data_oe;
    logic rom_cs_n;
    logic rom_oe_n;
    logic rom_we_n;
    int err_total = 0;
    int comparisons = 0;
    int n_cev = 0;
    int n_iev = 0;
    logic saw_rd = 1'b0;
    logic saw_wr = 1'b0;
    logic [31:0] v;

    always #2 hclk = ~hclk;

    pmtx_csr_bank #(.TICK_10_CYC(TICK10)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .tx_burst_done(tx_burst_done), .tx_burst_fail(tx_burst_fail), .tx_start(tx_start),
        .speed_100(speed_100), .duplex_collision_led(led), .power_state(power_state),
        .tx_complete_event(tx_complete_event), .tx_idle_event(tx_idle_event),
        .shared_pin_out(shared_pin_out), .rom_addr(rom_addr), .rom_data_in(rom_data_in),
        .rom_data_out(rom_data_out), .rom_data_oe(rom_data_oe), .rom_cs_n(rom_cs_n),
        .rom_oe_n(rom_oe_n), .rom_we_n(rom_we_n)
    );

    // ------------------------------------------------------------
    // flash part stand-in and event watchers
    // ------------------------------------------------------------
    always @(posedge hclk)
    begin
        // undriven pins toggle so a stale byte cannot pass
        rom_data_in <= (rom_oe_n === 1'b0 && rom_cs_n === 1'b0) ? rom_byte : ~rom_data_in;
        if (tx_complete_event === 1'b1)
            n_cev <= n_cev + 1;
        if (tx_idle_event === 1'b1)
            n_iev <= n_iev + 1;
        if (rom_cs_n === 1'b0 && rom_oe_n === 1'b0 && rom_addr === 17'h1abcd)
            saw_rd <= 1'b1;
        if (rom_cs_n === 1'b0 && rom_we_n === 1'b0 && rom_data_oe === 1'b1
            && rom_data_out === 8'hc3 && rom_addr === 17'h00123)
            saw_wr <= 1'b1;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic give_verdict;
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            err_total++;
            give_verdict;
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        wait_ready;
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        wait_ready;
        r = hrdata;
        check32({31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check32(r, exp);
    endtask

    task automatic tx_pulse(input logic ok);
        if (ok)
            tx_burst_done <= 1'b1;
        else
            tx_burst_fail <= 1'b1;
        @(posedge hclk);
        tx_burst_done <= 1'b0;
        tx_burst_fail <= 1'b0;
        cyc(4);
    endtask

    // software waits on the request bit, as a driver would
    task automatic poll_clear(input int b, output logic [31:0] r);
        int n;
        n = 0;
        do
        begin
            bus(1'b0, pmtx_pkg::ADDR_FROM, 32'h0, r);
            n++;
        end
        while (r[b] !== 1'b0 && n < 40);
        if (r[b] !== 1'b0)
        begin
            err_total++;
            give_verdict;
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    logic [1:0] ps_wr [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
    logic [1:0] ps_exp [4] = '{2'h3, 2'h3, 2'h3, 2'h0};

    initial
    begin
        cyc(3);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(pmtx_pkg::ADDR_TX_BURST, 32'h00050000);
        rd_chk(pmtx_pkg::ADDR_FROM, 32'h80000000);
        rd_chk(pmtx_pkg::ADDR_PM_CSR, 32'h0);
        wr(8'hf0, 32'hffffffff);
        rd_chk(8'hf0, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            wr(pmtx_pkg::ADDR_PM_CSR, {30'h0, ps_wr[i]});
            rd_chk(pmtx_pkg::ADDR_PM_CSR, {30'h0, ps_exp[i]});
            check32({30'h0, power_state}, {30'h0, ps_exp[i]});
        end
        // default threshold of five, then two with a failure between
        repeat (4) tx_pulse(1'b1);
        check32(n_cev, 32'h0);
        tx_pulse(1'b1);
        check32(n_cev, 32'h1);
        wr(pmtx_pkg::ADDR_TX_BURST, 32'h00020000);
        tx_pulse(1'b1);
        tx_pulse(1'b0);
        tx_pulse(1'b1);
        check32(n_cev, 32'h1);
        tx_pulse(1'b1);
        check32(n_cev, 32'h2);
        // idle timer at 10M, three steps of TICK10, then one 100M step and detection off
        wr(pmtx_pkg::ADDR_IRQ_EN, 32'h10000000);
        rd_chk(pmtx_pkg::ADDR_IRQ_EN, 32'h10000000);
        wr(pmtx_pkg::ADDR_TX_BURST, 32'h00020003);
        rd_chk(pmtx_pkg::ADDR_TX_BURST, 32'h00020003);
        cyc(30);
        check32(n_iev, 32'h0);
        cyc(40);
        check32(n_iev, 32'h1);
        wr(pmtx_pkg::ADDR_TX_BURST, 32'h00020003);
        cyc(30);
        tx_start <= 1'b1;
        @(posedge hclk);
        tx_start <= 1'b0;
        cyc(30);
        check32(n_iev, 32'h1);
        cyc(40);
        check32(n_iev, 32'h2);
        speed_100 <= 1'b1;
        wr(pmtx_pkg::ADDR_TX_BURST, 32'h00020001);
        cyc(600);
        check32(n_iev, 32'h2);
        cyc(100);
        check32(n_iev, 32'h3);
        wr(pmtx_pkg::ADDR_IRQ_EN, 32'h0);
        wr(pmtx_pkg::ADDR_TX_BURST, 32'h00020001);
        cyc(700);
        check32(n_iev, 32'h3);
        // shared pin steering
        wr(pmtx_pkg::ADDR_LED_CFG, 32'h00800000);
        wr(pmtx_pkg::ADDR_FROM, 32'h81000000);
        cyc(3);
        check32({31'h0, shared_pin_out}, 32'h1);
        led <= 1'b1;
        wr(pmtx_pkg::ADDR_FROM, 32'h01000000);
        cyc(3);
        check32({31'h0, shared_pin_out}, 32'h1);
        led <= 1'b0;
        cyc(3);
        check32({31'h0, shared_pin_out}, 32'h0);
        wr(pmtx_pkg::ADDR_LED_CFG, 32'h0);
        wr(pmtx_pkg::ADDR_FROM, 32'h81000000);
        cyc(3);
        check32({31'h0, shared_pin_out}, 32'h0);
        // flash byte read then write
        wr(pmtx_pkg::ADDR_FROM, 32'h89abcd00);
        poll_clear(27, v);
        check32(v, 32'h81abcd5a);
        check32({31'h0, saw_rd}, 32'h1);
        wr(pmtx_pkg::ADDR_FROM, 32'h840123c3);
        poll_clear(26, v);
        check32(v, 32'h800123c3);
        check32({31'h0, saw_wr}, 32'h1);
        check32({29'h0, rom_cs_n, rom_oe_n, rom_we_n}, 32'h7);
        give_verdict;
    end
endmodule
